// File: pfs_host.v
/*
 parallel flash programmer controller: drives the flash device's
 strobes, address and data pins to read, program (with verify loop),
 erase (with pre-zero and verify loop), reset, and protect readout.
 assumes data pins come back asynchronously and are synchronised here;
 the device's write-permit select and programming voltage pins are held.
*/
`timescale 1ns/1ps
`include "pfs_consts.vh"

// Behaviour
// - each operation chosen by writing a command byte on data pins
// - wait at least 20 us after program data cycle
// - program-verify after each program, repeat until data matches; code stops after MAX_TRIES programs and sets o_fail
// - wait at least 20 ms after second erase cycle
// - program every location to 00 before first erase; code zeroes only i_addr to i_addr_end
// - erase-verify after each erase, repeat until it passes; code stops after MAX_TRIES failed verifies and sets o_fail
// - repeat erases need no programming to 00 beforehand
// - write cycle: permit high, chip select low, output enable high
module pfs_host #(
  parameter ADDR_W = 17,
  parameter PROG_CYC = `PFS_PROG_CYC,
  parameter ERASE_CYC = `PFS_ERASE_CYC,
  parameter MAX_TRIES = 25
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // user request
  input wire i_start,
  input wire [2:0] i_op,
  input wire [ADDR_W-1:0] i_addr,
  input wire [ADDR_W-1:0] i_addr_end,
  input wire [7:0] i_data,
  output wire o_ready,
  output reg o_done,
  output reg o_fail,
  output reg [7:0] o_rdata,
  output reg o_protected,
  // device pins
  output reg [ADDR_W-1:0] o_addr,
  output reg [7:0] o_dq_out,
  output reg o_dq_oe_n,
  input wire [7:0] i_dq_in,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg o_write_permit_select,
  output reg o_programming_voltage_mode_pin
);

  // ********************************
  // states
  // ********************************
  localparam S_IDLE = 4'h0;
  localparam S_WR = 4'h1;
  localparam S_RD = 4'h2;
  localparam S_WAIT = 4'h3;
  localparam S_DISPATCH = 4'h4;
  localparam S_FINISH = 4'h5;

  // step codes held in step_reg
  localparam T_READ = 4'h0;
  localparam T_PCMD = 4'h1;
  localparam T_PDAT = 4'h2;
  localparam T_PVCMD = 4'h3;
  localparam T_PVRD = 4'h4;
  localparam T_ZCMD = 4'h5;
  localparam T_ZDAT = 4'h6;
  localparam T_ZVCMD = 4'h7;
  localparam T_ZVRD = 4'h8;
  localparam T_E1 = 4'h9;
  localparam T_E2 = 4'ha;
  localparam T_EVCMD = 4'hb;
  localparam T_EVRD = 4'hc;
  localparam T_R1 = 4'hd;
  localparam T_R2 = 4'he;
  localparam T_RCMD = 4'hf;

  reg [3:0] state_reg;
  reg [3:0] step_reg;
  reg [2:0] op_reg;
  reg [ADDR_W-1:0] cur_reg;
  reg [ADDR_W-1:0] end_reg;
  reg [ADDR_W-1:0] base_reg;
  reg [7:0] data_reg;
  reg [2:0] phase_reg;
  reg [24:0] wait_reg;
  reg [7:0] tries_reg;
  reg [7:0] dq_meta_reg;
  reg [7:0] dq_sync_reg;

  assign o_ready = (state_reg == S_IDLE);

  // is this step a write cycle
  function is_write;
    input [3:0] s;
    begin
      is_write = !(s == T_READ || s == T_PVRD || s == T_ZVRD || s == T_EVRD);
    end
  endfunction

  // data byte driven in a write step
  function [7:0] wr_byte;
    input [3:0] s;
    input [7:0] d;
    begin
      case (s)
        T_PCMD, T_ZCMD: wr_byte = `PFS_CMD_PROG;
        T_PDAT: wr_byte = d;
        T_ZDAT: wr_byte = `PFS_ZERO_BYTE;
        T_PVCMD, T_ZVCMD: wr_byte = `PFS_CMD_PVFY;
        T_E1, T_E2: wr_byte = `PFS_CMD_ERASE;
        T_EVCMD: wr_byte = `PFS_CMD_EVFY;
        T_RCMD: wr_byte = `PFS_CMD_READ;
        default: wr_byte = `PFS_CMD_RESET;
      endcase
    end
  endfunction

  // ********************************
  // data pin synchroniser
  // ********************************
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dq_meta_reg <= 8'h00;
      dq_sync_reg <= 8'h00;
    end else begin
      dq_meta_reg <= i_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ********************************
  // sequencer
  // ********************************
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
      step_reg <= T_READ;
      op_reg <= 3'h0;
      cur_reg <= {ADDR_W{1'b0}};
      end_reg <= {ADDR_W{1'b0}};
      base_reg <= {ADDR_W{1'b0}};
      data_reg <= 8'h00;
      phase_reg <= 3'h0;
      wait_reg <= 25'h0000000;
      tries_reg <= 8'h00;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_rdata <= 8'h00;
      o_protected <= 1'b0;
      o_addr <= {ADDR_W{1'b0}};
      o_dq_out <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_write_permit_select <= 1'b0;
      o_programming_voltage_mode_pin <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_write_permit_select <= 1'b1;
      o_programming_voltage_mode_pin <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          o_ce_n <= 1'b1;
          if (i_start) begin
            op_reg <= i_op;
            cur_reg <= i_addr;
            end_reg <= i_addr_end;
            base_reg <= i_addr;
            data_reg <= i_data;
            tries_reg <= 8'h00;
            o_fail <= 1'b0;
            phase_reg <= 3'h0;
            state_reg <= S_DISPATCH;
            case (i_op)
              `PFS_OP_PROGRAM: step_reg <= T_PCMD;
              `PFS_OP_ERASE: step_reg <= T_ZCMD;
              `PFS_OP_RESET: step_reg <= T_R1;
              `PFS_OP_PROTECT: step_reg <= T_RCMD;
              default: step_reg <= T_RCMD;
            endcase
            if (i_op == `PFS_OP_PROTECT) begin
              cur_reg <= `PFS_PROTECT_ADDR;
            end
          end
        end
        S_DISPATCH: begin
          phase_reg <= 3'h0;
          o_ce_n <= 1'b0;
          o_addr <= cur_reg;
          state_reg <= is_write(step_reg) ? S_WR : S_RD;
        end
        S_WR: begin
          o_oe_n <= 1'b1;
          o_dq_oe_n <= 1'b0;
          o_dq_out <= wr_byte(step_reg, data_reg);
          phase_reg <= phase_reg + 3'h1;
          o_we_n <= !(phase_reg >= 3'h1 && phase_reg < 3'h1 + `PFS_STROBE_CYC);
          if (phase_reg == 3'h1 + `PFS_STROBE_CYC + 3'h1) begin
            o_dq_oe_n <= 1'b1;
            wait_reg <= 25'h0000000;
            state_reg <= S_WAIT;
          end
        end
        S_RD: begin
          o_dq_oe_n <= 1'b1;
          o_oe_n <= 1'b0;
          phase_reg <= phase_reg + 3'h1;
          if (phase_reg == 3'h6) begin
            o_oe_n <= 1'b1;
            wait_reg <= 25'h0000000;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          wait_reg <= wait_reg + 25'h0000001;
          if ((step_reg == T_PDAT || step_reg == T_ZDAT) &&
              wait_reg < PROG_CYC[24:0] - 25'h1) begin
            state_reg <= S_WAIT;
          end else if (step_reg == T_E2 && wait_reg < ERASE_CYC[24:0] - 25'h1) begin
            state_reg <= S_WAIT;
          end else begin
            state_reg <= S_DISPATCH;
            case (step_reg)
              T_RCMD: step_reg <= T_READ;
              T_READ: begin
                o_rdata <= dq_sync_reg;
                if (op_reg == `PFS_OP_PROTECT) begin
                  o_protected <= (dq_sync_reg & `PFS_PROTECT_MASK) != `PFS_PROTECT_MASK;
                end
                state_reg <= S_FINISH;
              end
              T_PCMD: step_reg <= T_PDAT;
              T_PDAT: step_reg <= T_PVCMD;
              T_PVCMD: step_reg <= T_PVRD;
              T_PVRD: begin
                o_rdata <= dq_sync_reg;
                tries_reg <= tries_reg + 8'h01;
                if (dq_sync_reg == data_reg) begin
                  state_reg <= S_FINISH;
                end else if (tries_reg + 8'h01 >= MAX_TRIES[7:0]) begin
                  o_fail <= 1'b1;
                  step_reg <= T_R1;
                end else begin
                  step_reg <= T_PCMD;
                end
              end
              T_ZCMD: step_reg <= T_ZDAT;
              T_ZDAT: step_reg <= T_ZVCMD;
              T_ZVCMD: step_reg <= T_ZVRD;
              T_ZVRD: begin
                tries_reg <= tries_reg + 8'h01;
                if (dq_sync_reg == `PFS_ZERO_BYTE) begin
                  tries_reg <= 8'h00;
                  if (cur_reg == end_reg) begin
                    // held start address, the request inputs may have moved
                    cur_reg <= base_reg;
                    step_reg <= T_E1;
                  end else begin
                    cur_reg <= cur_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                    step_reg <= T_ZCMD;
                  end
                end else if (tries_reg + 8'h01 >= MAX_TRIES[7:0]) begin
                  o_fail <= 1'b1;
                  step_reg <= T_R1;
                end else begin
                  step_reg <= T_ZCMD;
                end
              end
              T_E1: step_reg <= T_E2;
              T_E2: step_reg <= T_EVCMD;
              T_EVCMD: step_reg <= T_EVRD;
              T_EVRD: begin
                if (dq_sync_reg != `PFS_ERASED_BYTE) begin
                  tries_reg <= tries_reg + 8'h01;
                  if (tries_reg + 8'h01 >= MAX_TRIES[7:0]) begin
                    o_fail <= 1'b1;
                    step_reg <= T_R1;
                  end else begin
                    step_reg <= T_E1;
                  end
                end else if (cur_reg == end_reg) begin
                  state_reg <= S_FINISH;
                end else begin
                  cur_reg <= cur_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                  step_reg <= T_EVCMD;
                end
              end
              T_R1: step_reg <= T_R2;
              default: state_reg <= S_FINISH;
            endcase
          end
        end
        S_FINISH: begin
          o_ce_n <= 1'b1;
          o_done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// File: pfs_consts.vh
/*
 header of constants for the parallel flash programmer controller:
 command codes, protect location, timing figures.
 assumes a 25 MHz controller clock; included by bare name.
*/
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ********************************
// command codes
// ********************************
`define PFS_CMD_READ 8'h00
`define PFS_CMD_PROG 8'h40
`define PFS_CMD_PVFY 8'hc0
`define PFS_CMD_ERASE 8'h20
`define PFS_CMD_EVFY 8'ha0
`define PFS_CMD_RESET 8'hff

// ********************************
// protect control location
// ********************************
`define PFS_PROTECT_ADDR 17'h0ffff
`define PFS_PROTECT_MASK 8'h03
`define PFS_ERASED_BYTE 8'hff
`define PFS_ZERO_BYTE 8'h00

// ********************************
// timing
// ********************************
`define PFS_CLK_MHZ 25
`define PFS_PROG_US 20
`define PFS_ERASE_MS 20
`define PFS_PROG_CYC (`PFS_PROG_US * `PFS_CLK_MHZ)
`define PFS_ERASE_CYC (`PFS_ERASE_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_STROBE_CYC 4

// ********************************
// user operations
// ********************************
`define PFS_OP_READ 3'h0
`define PFS_OP_PROGRAM 3'h1
`define PFS_OP_ERASE 3'h2
`define PFS_OP_RESET 3'h3
`define PFS_OP_PROTECT 3'h4

`endif

// File: pfs_monitor.sv
/*
 checker for the pin timing of pfs_host.
 assumes it is bound onto pfs_host.
*/
`timescale 1ns/1ps
module pfs_monitor #(
  parameter ADDR_W = 17
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // user side
  input wire i_start,
  input wire o_ready,
  input wire o_done,
  // device pins
  input wire [ADDR_W-1:0] o_addr,
  input wire [7:0] o_dq_out,
  input wire o_dq_oe_n,
  input wire o_ce_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire o_write_permit_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****************
  // strobe shapes
  // ****************
  sequence s_we_pulse;
    !o_we_n [*4] ##1 o_we_n;
  endsequence
  sequence s_rd_pulse;
    !o_oe_n [*5];
  endsequence
  a_done_one: assert property (o_done |=> !o_done)
    else $error("done pulse too long");
  a_start_busy: assert property (i_start && o_ready |=> !o_ready)
    else $error("request not taken");
  a_we_qual: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_write_permit_select)
    else $error("write strobe without select");
  a_we_width: assert property ($fell(o_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_data_setup: assert property ($fell(o_we_n) |-> !$past(o_dq_oe_n))
    else $error("data not driven before strobe");
  a_pins_hold: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq_out))
    else $error("address or data moved in strobe");
  a_bus_free: assert property (!o_oe_n |-> o_dq_oe_n && o_we_n)
    else $error("bus contention on read");
  a_read_width: assert property ($fell(o_oe_n) |-> s_rd_pulse)
    else $error("read strobe too short");
  a_permit_up: assert property ((!i_reset ##1 1) |-> o_write_permit_select)
    else $error("permit select low");
endmodule

// File: pfs_flash_model.sv
/*
 behavioural flash device: command decode, program, erase, verify.
 assumes pins driven by pfs_host; counts protocol slips in o_viol.
*/
`timescale 1ns/1ps
module pfs_flash_model #(
  parameter PROG_NS = 320,
  parameter ERASE_NS = 800
) (
  // device pins
  input wire [16:0] i_addr,
  input wire [7:0] i_dq,
  input wire i_dq_oe_n,
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire i_permit,
  output wire [7:0] o_dq,
  output int o_viol
);
  logic [7:0] mem [0:131071];
  logic [7:0] d, q, last = 8'h00, nx = 8'h00;
  logic [16:0] wa, pa, va;
  int md = 0;
  // set by a real falling strobe, so the reset edge of the strobe is no write
  logic wlow = 1'b0;
  realtime busy = 0;
  wire prot = (mem[17'h0ffff] & 8'h03) != 8'h03;
  assign q = (prot && i_addr != 17'h0ffff) ? 8'h00 :
    md == 2 ? mem[pa] : md == 4 ? mem[va] : mem[i_addr];
  assign o_dq = (!i_ce_n && !i_oe_n) ? q : ~last;
  always @(posedge i_oe_n) last = q;
  initial foreach (mem[i]) mem[i] = 8'hff;
  initial o_viol = 0;
  always @(negedge i_we_n) begin
    wa = i_addr;
    wlow = 1'b1;
    if (i_ce_n || !i_oe_n || !i_permit) o_viol++;
  end
  always @(posedge i_we_n) if (wlow) begin
    wlow = 1'b0;
    d = i_dq;
    if (i_dq_oe_n || $realtime < busy) o_viol++;
    if (md == 1) begin
      if (!prot) mem[wa] = mem[wa] & d;
      pa = wa;
      busy = $realtime + PROG_NS;
      nx = 8'hc0;
      md = 0;
    // second cycles of erase and reset
    end else if (md == 3 || md == 5) begin
      if (md == 3 && d == 8'h20) begin
        if (!prot) foreach (mem[i]) mem[i] = 8'hff;
        busy = $realtime + ERASE_NS;
        nx = 8'ha0;
      end
      md = 0;
    end else begin
      if (nx != 8'h00 && d != nx && d != 8'hff) o_viol++;
      nx = 8'h00;
      case (d)
        8'h00: md = 0;
        8'h40: md = 1;
        8'hc0: md = 2;
        8'h20: md = 3;
        8'ha0: begin
          va = wa;
          md = 4;
        end
        8'hff: md = 5;
        default: ;
      endcase
    end
  end
endmodule

// File: pfs_tb.sv
/*
 bench for pfs_host against the flash model and a reference array.
 assumes pfs_monitor and pfs_flash_model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_reset = 1, i_start = 0;
  logic [2:0] i_op = 0;
  logic [16:0] i_addr = 0, i_addr_end = 0;
  logic [7:0] i_data = 0, d;
  wire o_ready, o_done, o_fail, o_prot, dq_oe_n, ce_n, oe_n, we_n, wps, vpp;
  wire [7:0] o_rdata, dq_out, m_q;
  wire [16:0] addr;
  wire [7:0] bus = !dq_oe_n ? dq_out : m_q;
  int errors = 0, n_tests = 0, m_viol, k;
  int ref_mem [int];
  always #20 i_clk = ~i_clk;
  pfs_host #(.PROG_CYC(8), .ERASE_CYC(20)) u_pfs_host (.i_clk(i_clk), .i_reset(i_reset),
    .i_start(i_start), .i_op(i_op), .i_addr(i_addr), .i_addr_end(i_addr_end),
    .i_data(i_data), .o_ready(o_ready), .o_done(o_done), .o_fail(o_fail),
    .o_rdata(o_rdata), .o_protected(o_prot), .o_addr(addr), .o_dq_out(dq_out),
    .o_dq_oe_n(dq_oe_n), .i_dq_in(bus), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_write_permit_select(wps), .o_programming_voltage_mode_pin(vpp));
  pfs_flash_model u_pfs_flash_model (.i_addr(addr), .i_dq(bus), .i_dq_oe_n(dq_oe_n),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_permit(wps & vpp), .o_dq(m_q),
    .o_viol(m_viol));
  function automatic logic [7:0] rd(input int a);
    return ref_mem.exists(a) ? ref_mem[a][7:0] : 8'hff;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one request, bounded wait for done
  task automatic run(input logic [2:0] op, input logic [16:0] a, input logic [7:0] dt);
    i_op = op;
    i_addr = a;
    i_addr_end = 17'h00003;
    i_data = dt;
    i_start = 1;
    @(posedge i_clk);
    #1 i_start = 0;
    // request inputs may move once taken
    i_addr = 17'($urandom);
    k = 0;
    while (o_done !== 1'b1 && k < 20000) begin
      @(posedge i_clk);
      #1 k++;
    end
    if (k >= 20000) begin
      errors++;
      results;
    end
  endtask
  // main sequence
  initial begin
    d = $urandom(32'h202d);
    repeat (5) @(posedge i_clk);
    #1 i_reset = 0;
    chk({7'h0, o_ready}, 8'h01);
    for (int i = 0; i < 12; i += 3) begin
      d = $urandom;
      run(1, 17'(i), d);
      ref_mem[i] = d;
      chk(o_rdata, d);
      run(0, 17'(i), 0);
      chk(o_rdata, rd(i));
    end
    run(5, 17'h00003, 0);
    chk(o_rdata, rd(3));
    chk({7'h0, o_prot}, 8'h00);
    $display("test program and read ended");
    run(2, 17'h00000, 0);
    chk({7'h0, o_fail}, 8'h00);
    ref_mem.delete();
    for (int i = 0; i < 12; i += 3) begin
      run(0, 17'(i), 0);
      chk(o_rdata, rd(i));
    end
    run(3, 17'h00000, 0);
    chk({7'h0, o_fail}, 8'h00);
    $display("test erase and reset ended");
    run(4, 17'h00000, 0);
    chk({7'h0, o_prot}, 8'h00);
    run(1, 17'h0ffff, 8'hfe);
    run(4, 17'h00000, 0);
    chk({7'h0, o_prot}, 8'h01);
    run(0, 17'h00006, 0);
    chk(o_rdata, 8'h00);
    run(1, 17'h0ffff, 8'hfc);
    chk({7'h0, o_fail}, 8'h01);
    chk((m_viol > 255) ? 8'hff : m_viol[7:0], 8'h00);
    $display("test protect ended");
    results;
  end
endmodule
bind pfs_host pfs_monitor #(.ADDR_W(ADDR_W)) u_pfs_monitor (.i_clk(i_clk),
  .i_reset(i_reset), .i_start(i_start), .o_ready(o_ready), .o_done(o_done),
  .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_write_permit_select(o_write_permit_select));
